// >>> logic/iit_idle_timer.v
`timescale 1ns/1ps
`include "iit_defs.vh"

// Summary of operation
// - Hidden 16-bit down-counter, no software access.
// - High speed mode counts instruction clock ticks.
// - Dual clock or low speed counts 32 kHz.
// - Instruction clock divider stopped in slow modes.
// - Tap bit 11..15 sets the period.
// - Tap underflow sets the pending flag.
// - Tap underflow clears wake port bit 6.
// - Interrupt needs pending, enable and global enable.
// - Pending is bit 5, enable bit 4.
// - Period select in bits 2..0.
// - Reset clears period select to 4096 cycles.
// - Bits 7..4 hold dual clock controls.
// - Counter also gives watchdog and start-up time base.
// - Zeros in upper control bits reset device.
module iit_idle_timer (
   // Clock and reset
   input wire clk,
   input wire arst_n,
   // Register port
   input wire [`IIT_ADDR_W-1:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   // Slow 32 kHz clock, sampled as a level
   input wire slow_clk_in,
   // Interrupts
   output reg idle_irq,
   output reg irq,
   // Wake and power control
   output reg wake_port_bit6,
   output reg idle_exit,
   output reg device_reset_req,
   // Time base for watchdog and start-up delays
   output reg timebase_tick,
   output reg period_end,
   output reg [4:0] timebase_taps
);

   reg [7:0] idle_period_register;
   reg idle_pending_flag;
   reg idle_irq_enable;
   reg global_irq_enable;
   reg [`IIT_EV_W-1:0] ev_status;
   reg [`IIT_EV_W-1:0] ev_mask;
   reg [`IIT_CNT_W-1:0] idle_timer;
   reg slow_prev;
   reg next_pending;
   reg next_wake;
   reg [7:0] next_rdata;

   wire [2:0] sel;
   wire slow_mode;
   wire inst_tick;
   wire slow_tick;
   wire count_tick;
   wire wr_period;
   wire wr_ictrl;
   wire wr_wake;
   wire wr_evstat;
   wire wr_evmask;
   wire [`IIT_CNT_W-1:0] tap_mask;
   wire underflow;
   wire [`IIT_EV_W-1:0] ev_set;
   wire [`IIT_EV_W-1:0] ev_clr;

   assign sel = idle_period_register[`IIT_SEL_MSB:`IIT_SEL_LSB];
   // Either dual clock control selects the 32 kHz source
   assign slow_mode = idle_period_register[`IIT_DUALCLK_BIT] |
                      idle_period_register[`IIT_CORECLK_BIT];

   iit_tick_gen #(
      .DIV(`IIT_INST_DIV),
      .W(`IIT_DIV_W)
   ) u_inst_div (
      .clk(clk),
      .arst_n(arst_n),
      .run(~slow_mode),
      .tick(inst_tick)
   );

   // Slow clock is synchronous per system; rising edge is a tick
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         slow_prev <= 1'b0;
      end else begin
         slow_prev <= slow_clk_in;
      end
   end
   assign slow_tick = slow_clk_in & ~slow_prev;

   assign count_tick = slow_mode ? slow_tick : inst_tick;

   // Mask of the tap bit and all bits below it
   function [`IIT_CNT_W-1:0] tap_bits;
      input [2:0] code;
      begin
         case (code)
            3'h0: tap_bits = 16'h0FFF;
            3'h1: tap_bits = 16'h1FFF;
            3'h2: tap_bits = 16'h3FFF;
            3'h3: tap_bits = 16'h7FFF;
            default: tap_bits = 16'hFFFF;
         endcase
      end
   endfunction

   // Reserved codes fall back to the top tap
   assign tap_mask = tap_bits(sel);
   // Tap bit goes 0 to 1 when it and all lower bits were zero
   assign underflow = count_tick & ((idle_timer & tap_mask) == 16'h0000);

   // Counter is never written by software; it free-runs
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         idle_timer <= 16'h0000;
      end else if (count_tick) begin
         idle_timer <= idle_timer - 16'h0001;
      end
   end

   assign wr_period = reg_wr & (reg_addr == `IIT_OFF_PERIOD);
   assign wr_ictrl = reg_wr & (reg_addr == `IIT_OFF_ICTRL);
   assign wr_wake = reg_wr & (reg_addr == `IIT_OFF_WAKE);
   assign wr_evstat = reg_wr & (reg_addr == `IIT_OFF_EVSTAT);
   assign wr_evmask = reg_wr & (reg_addr == `IIT_OFF_EVMASK);

   // Period and clock control register
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         idle_period_register <= `IIT_PERIOD_RST;
         device_reset_req <= 1'b0;
      end else begin
         device_reset_req <= 1'b0;
         if (wr_period) begin
            // Reserved bit is not stored
            idle_period_register <= reg_wdata & `IIT_PERIOD_WMASK;
            if (reg_wdata[7:4] == 4'h0) begin
               device_reset_req <= 1'b1;
            end
         end
      end
   end

   // Interrupt control; hardware set wins over a software clear
   always @* begin
      next_pending = idle_pending_flag;
      if (underflow) begin
         next_pending = 1'b1;
      end else if (wr_ictrl) begin
         next_pending = reg_wdata[`IIT_PND_BIT];
      end
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         idle_pending_flag <= 1'b0;
         idle_irq_enable <= 1'b0;
         global_irq_enable <= 1'b0;
      end else begin
         idle_pending_flag <= next_pending;
         if (wr_ictrl) begin
            idle_irq_enable <= reg_wdata[`IIT_EN_BIT];
            global_irq_enable <= reg_wdata[`IIT_GLOBEN_BIT];
         end
      end
   end

   // Wake port bit: software sets it, underflow clears it
   always @* begin
      next_wake = wake_port_bit6;
      if (underflow) begin
         next_wake = 1'b0;
      end else if (wr_wake) begin
         next_wake = reg_wdata[`IIT_WAKE_BIT];
      end
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wake_port_bit6 <= 1'b1;
         idle_exit <= 1'b0;
      end else begin
         idle_exit <= underflow & wake_port_bit6;
         wake_port_bit6 <= next_wake;
      end
   end

   // Event status, write one to clear, set wins
   assign ev_set = {device_reset_req, idle_exit, underflow};
   assign ev_clr = wr_evstat ? reg_wdata[`IIT_EV_W-1:0] :
                   {`IIT_EV_W{1'b0}};

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ev_status <= {`IIT_EV_W{1'b0}};
         ev_mask <= {`IIT_EV_W{1'b0}};
      end else begin
         ev_status <= (ev_status & ~ev_clr) | ev_set;
         if (wr_evmask) begin
            ev_mask <= reg_wdata[`IIT_EV_W-1:0];
         end
      end
   end

   // Interrupt outputs and time base
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         idle_irq <= 1'b0;
         irq <= 1'b0;
         period_end <= 1'b0;
         timebase_tick <= 1'b0;
         timebase_taps <= 5'h00;
      end else begin
         idle_irq <= idle_pending_flag & idle_irq_enable &
                     global_irq_enable;
         irq <= |(ev_status & ev_mask);
         period_end <= underflow;
         timebase_tick <= count_tick;
         timebase_taps <= idle_timer[`IIT_TAP_TOP:`IIT_TAP_BASE];
      end
   end

   // Read port: counter is not visible, unmapped reads give zero
   always @* begin
      next_rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            `IIT_OFF_PERIOD: next_rdata = idle_period_register;
            `IIT_OFF_ICTRL: next_rdata = {2'b00, idle_pending_flag,
                                          idle_irq_enable, 3'b000,
                                          global_irq_enable};
            `IIT_OFF_EVSTAT: next_rdata = {5'h00, ev_status};
            `IIT_OFF_EVMASK: next_rdata = {5'h00, ev_mask};
            `IIT_OFF_WAKE: next_rdata = {1'b0, wake_port_bit6, 6'h00};
            default: next_rdata = 8'h00;
         endcase
      end
   end

   // Data stand for one cycle only, zero otherwise
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

endmodule // iit_idle_timer

// >>> logic/iit_defs.vh
`ifndef IIT_DEFS_VH
`define IIT_DEFS_VH

// Register offsets on the plain register port
`define IIT_ADDR_W 3
`define IIT_OFF_PERIOD 3'h0
`define IIT_OFF_ICTRL 3'h1
`define IIT_OFF_EVSTAT 3'h2
`define IIT_OFF_EVMASK 3'h3
`define IIT_OFF_WAKE 3'h4

// Period and clock control register fields
`define IIT_SEL_LSB 0
`define IIT_SEL_MSB 2
`define IIT_RSVD_BIT 3
`define IIT_CORECLK_BIT 4
`define IIT_DUALCLK_BIT 5
`define IIT_FASTON_BIT 6
`define IIT_SLOWON_BIT 7
`define IIT_PERIOD_RST 8'h40
`define IIT_PERIOD_WMASK 8'hF7

// Interrupt control register fields
`define IIT_GLOBEN_BIT 0
`define IIT_EN_BIT 4
`define IIT_PND_BIT 5

// Event status and mask bits
`define IIT_EV_TAP 0
`define IIT_EV_WAKE 1
`define IIT_EV_RSTREQ 2
`define IIT_EV_W 3

// Wake port bit position
`define IIT_WAKE_BIT 6

// Counter and taps
`define IIT_CNT_W 16
`define IIT_TAP_BASE 11
`define IIT_TAP_TOP 15
`define IIT_SEL_MAXCODE 3'h4

// Instruction clock: core clock divided by 10 (oscillator / 5)
`define IIT_INST_DIV 10
`define IIT_DIV_W 4

`endif

// >>> logic/iit_tick_gen.v
`timescale 1ns/1ps

module iit_tick_gen #(
   parameter DIV = 10,
   parameter W = 4
) (
   // Clock and reset
   input wire clk,
   input wire arst_n,
   // Control
   input wire run,
   // Tick out
   output reg tick
);

   localparam integer LAST_I = DIV - 1;
   localparam [W-1:0] LAST = LAST_I[W-1:0];

   reg [W-1:0] count;

   // Held in reset while stopped so no power is spent toggling
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count <= {W{1'b0}};
         tick <= 1'b0;
      end else if (!run) begin
         count <= {W{1'b0}};
         tick <= 1'b0;
      end else if (count == LAST) begin
         count <= {W{1'b0}};
         tick <= 1'b1;
      end else begin
         count <= count + {{(W-1){1'b0}}, 1'b1};
         tick <= 1'b0;
      end
   end

endmodule // iit_tick_gen

// >>> verification/iit_idle_timer_sva.sv
`timescale 1ns/1ps
`include "iit_defs.vh"
module iit_idle_timer_sva (
   // Clock, reset, register port
   input logic clk,
   input logic arst_n,
   input logic [`IIT_ADDR_W-1:0] reg_addr,
   input logic [7:0] reg_wdata,
   input logic reg_wr,
   input logic reg_rd,
   input logic [7:0] reg_rdata,
   // Timer outputs
   input logic idle_irq,
   input logic irq,
   input logic wake_port_bit6,
   input logic idle_exit,
   input logic device_reset_req,
   input logic period_end,
   input logic [4:0] timebase_taps
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("rdata off slot");
   AST_RSVD: assert property ($past(reg_rd) && $past(reg_addr) == 3'h0
      |-> !reg_rdata[3]) else $error("rsvd bit");
   AST_WAKE: assert property (period_end |-> !wake_port_bit6)
      else $error("wake");
   AST_EXIT: assert property (period_end && $past(wake_port_bit6)
      |-> idle_exit) else $error("exit");
   AST_EXIT_PE: assert property (idle_exit |-> period_end)
      else $error("exit pe");
   AST_DOWN: assert property ($changed(timebase_taps)
      |-> timebase_taps == $past(timebase_taps) - 5'h01) else $error("taps");
   AST_IDLE_IRQ: assert property ($rose(idle_irq)
      |-> $past(period_end) || $past(reg_wr, 2)) else $error("idle irq");
   AST_IRQ: assert property ($rose(irq)
      |-> $past(period_end) || $past(reg_wr, 2) || $past(idle_exit, 2)
      || $past(device_reset_req, 2)) else $error("irq");
   AST_RST_REQ: assert property (device_reset_req == ($past(reg_wr) &&
      $past(reg_addr) == 3'h0 && $past(reg_wdata[7:4]) == 4'h0))
      else $error("rst req");
   // Shortest period is thousands of ticks, so 8 is safe
   AST_PE_GAP: assert property (period_end |=> !period_end [*8])
      else $error("pe gap");
   COV_PE: cover property (period_end);
   COV_IRQ: cover property ($rose(idle_irq));
   COV_RST: cover property (device_reset_req);
endmodule // iit_idle_timer_sva

bind iit_idle_timer iit_idle_timer_sva u_sva (.clk(clk), .arst_n(arst_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .idle_irq(idle_irq), .irq(irq),
   .wake_port_bit6(wake_port_bit6), .idle_exit(idle_exit),
   .device_reset_req(device_reset_req), .period_end(period_end),
   .timebase_taps(timebase_taps));

// >>> verification/iit_idle_timer_tb.sv
`timescale 1ns/1ps
`include "iit_defs.vh"
module iit_idle_timer_tb;
   logic clk, arst_n, reg_wr, reg_rd, slow_clk_in, rd_d;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata, rv;
   wire [7:0] reg_rdata;
   wire idle_irq, irq, wake_port_bit6, idle_exit, device_reset_req;
   wire timebase_tick, period_end;
   wire [4:0] timebase_taps;
   logic [7:0] expq[$];
   logic [2:0] ta[8] = '{1, 1, 1, 1, 1, 3, 2, 3};
   logic [7:0] td[8] = '{8'h31, 8'h21, 8'h30, 8'h11, 8'h31, 1, 3, 4};
   logic [1:0] te[8] = '{2, 0, 0, 0, 2, 3, 2, 2};
   int err_total, total_checks, n, m, i, c;
   iit_idle_timer dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .slow_clk_in(slow_clk_in),
      .idle_irq(idle_irq), .irq(irq), .wake_port_bit6(wake_port_bit6),
      .idle_exit(idle_exit), .device_reset_req(device_reset_req),
      .timebase_tick(timebase_tick), .period_end(period_end),
      .timebase_taps(timebase_taps));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task chk(input logic [15:0] s, input logic [15:0] e);
      total_checks++;
      if (s !== e) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task end_of_test;
      $display("checks=%0d mismatches=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      expq.push_back(e);
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask
   // Counts ticks and cycles up to the next underflow or tick
   task wait_ev(input bit pe, output int t, output int cy);
      t = 0;
      cy = 0;
      do begin
         @(posedge clk);
         #1;
         t += timebase_tick;
         cy++;
      end while ((pe ? period_end : timebase_tick) !== 1'b1 && cy < 40000);
   endtask
   // Slow clock runs far above 32 kHz to keep the run short
   always @(posedge clk) begin
      slow_clk_in <= ~slow_clk_in;
      if (rd_d === 1'b1)
         chk(reg_rdata, expq.pop_front());
      rd_d <= reg_rd;
   end
   initial begin
      arst_n = 1'b0;
      {reg_wr, reg_rd, rd_d, slow_clk_in} = 4'h0;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      err_total = 0;
      total_checks = 0;
      void'($urandom(94233));
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      rd(`IIT_OFF_WAKE, 8'h40);
      rd(`IIT_OFF_ICTRL, 8'h00);
      rd(`IIT_OFF_PERIOD, 8'h40);
      rd(3'h5, 8'h00);
      wait_ev(1, n, m);
      chk({wake_port_bit6, idle_exit}, 2'b01);
      rd(`IIT_OFF_ICTRL, 8'h20);
      rd(`IIT_OFF_EVSTAT, 8'h03);
      $display("reset and underflow test done");
      for (i = 0; i < 8; i++) begin
         wr(ta[i], td[i]);
         repeat (2) @(posedge clk);
         #1 chk({idle_irq, irq}, te[i]);
      end
      wr(`IIT_OFF_PERIOD, 8'h05);
      #1 chk(device_reset_req, 1);
      rd(`IIT_OFF_PERIOD, 8'h05);
      #1 chk(irq, 1);
      wr(`IIT_OFF_EVSTAT, 8'h04);
      wr(`IIT_OFF_PERIOD, 8'h68);
      rd(`IIT_OFF_PERIOD, 8'h60);
      $display("interrupt test done");
      repeat (3) wait_ev(0, n, m);
      chk(m, 2);
      rv = $urandom;
      for (i = 0; i < 2; i++) begin
         c = i ^ rv[0];
         wr(`IIT_OFF_ICTRL, 8'h01);
         wr(`IIT_OFF_PERIOD, {5'h0C, c[2:0]});
         wr(`IIT_OFF_ICTRL, 8'h01);
         wait_ev(1, n, m);
         wait_ev(1, n, m);
         chk(n, 16'h1000 << c);
      end
      rv = $urandom;
      wr(`IIT_OFF_WAKE, rv);
      rd(`IIT_OFF_WAKE, rv & 8'h40);
      $display("slow period test done");
      wr(`IIT_OFF_PERIOD, 8'h40);
      repeat (3) wait_ev(0, n, m);
      chk(m, 10);
      arst_n <= 1'b0;
      @(posedge clk);
      arst_n <= 1'b1;
      rd(`IIT_OFF_PERIOD, 8'h40);
      rd(`IIT_OFF_WAKE, 8'h40);
      repeat (2) @(posedge clk);
      $display("fast clock and reset test done");
      end_of_test;
   end
   // Run needs about 50k cycles
   initial begin
      #2500000;
      err_total++;
      end_of_test;
   end
endmodule // iit_idle_timer_tb
